// file: mrx_consts.vh
// Register offsets, field positions and reset values for the receive control block
`ifndef MRX_CONSTS_VH
`define MRX_CONSTS_VH

`define MRX_OFS_TX_STATUS     8'h72
`define MRX_OFS_RX_CTRL_ONE   8'h74

`define MRX_TXS_LATE_BIT      13
`define MRX_TXS_MAXCOL_BIT    12
`define MRX_TXS_ID_MSB        5

`define MRX_RC_FLUSH_BIT      15
`define MRX_RC_UDP_BIT        14
`define MRX_RC_TCP_BIT        13
`define MRX_RC_IP_BIT         12
`define MRX_RC_UCFILT_BIT     11
`define MRX_RC_PAUSE_BIT      10
`define MRX_RC_CRCACC_BIT     9
`define MRX_RC_MCFILT_BIT     8
`define MRX_RC_BCAST_BIT      7
`define MRX_RC_ALLMC_BIT      6
`define MRX_RC_OWNUC_BIT      5
`define MRX_RC_PROMISC_BIT    4
`define MRX_RC_INVERSE_BIT    1
`define MRX_RC_RUN_BIT        0

`define MRX_RC_RESET          16'h0800
`define MRX_RC_WRITE_MASK     16'hfff3

`define MRX_PAUSE_QUANTUM     7'h40

`endif

// file: mrx_pause_timer.v
// Pause timer holding transmission while a received pause request runs
`timescale 1ns/1ps
module mrx_pause_timer (
    // Clock and reset
    input  wire        clk,
    input  wire        reset_n,
    // Load request
    input  wire        load,
    input  wire [15:0] quanta,
    // Hold out
    output reg         hold
);
`include "mrx_consts.vh"

    reg [15:0] quanta_left;
    reg [6:0]  bit_count;

    // One quantum is 512 bit times; one clock stands for eight bit times
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            quanta_left <= 16'h0000;
            bit_count   <= 7'h00;
            hold        <= 1'b0;
        end else if (load) begin
            quanta_left <= quanta;
            bit_count   <= 7'h00;
            hold        <= (quanta != 16'h0000);
        end else if (quanta_left != 16'h0000) begin
            if (bit_count == `MRX_PAUSE_QUANTUM - 7'h01) begin
                bit_count   <= 7'h00;
                quanta_left <= quanta_left - 16'h0001;
                hold        <= (quanta_left != 16'h0001);
            end else begin
                bit_count <= bit_count + 7'h01;
            end
        end else begin
            hold <= 1'b0;
        end
    end

endmodule

// file: mrx_rx_control.v
// Receive control register, frame acceptance and transmit status report
`timescale 1ns/1ps
module mrx_rx_control (
    // Clock and reset
    input  wire        clk,
    input  wire        reset_n,
    // Register port
    input  wire [7:0]  reg_addr,
    input  wire        reg_write,
    input  wire        reg_read,
    input  wire [15:0] reg_wdata,
    output reg  [15:0] reg_rdata,
    // Station address and hash filter result
    input  wire [47:0] station_addr,
    input  wire        hash_hit,
    // Link mode
    input  wire        full_duplex,
    // Received frame summary from the receive MAC
    input  wire        rx_frame_start,
    input  wire [47:0] rx_dest_addr,
    input  wire        rx_frame_end,
    input  wire        rx_crc_error,
    input  wire        rx_is_ip,
    input  wire        rx_ip_sum_bad,
    input  wire        rx_is_udp,
    input  wire        rx_udp_sum_bad,
    input  wire        rx_is_tcp,
    input  wire        rx_tcp_sum_bad,
    input  wire        rx_is_pause,
    input  wire [15:0] rx_pause_quanta,
    // Transmit completion from the transmit MAC
    input  wire        tx_done,
    input  wire [5:0]  tx_done_id,
    input  wire        tx_late_collision,
    input  wire        tx_max_collision,
    // Results
    output reg         rx_frame_store,
    output reg         rx_frame_drop,
    output reg         rx_running,
    output reg         rx_queue_clear,
    output reg         tx_pause_hold
);
`include "mrx_consts.vh"

    ////////////////////////////////////////////////////////////////////////////////
    // Registers

    reg  [15:0] receive_control_one;
    reg  [15:0] transmit_status;
    wire        in_frame;
    reg         frame_ok_run;
    reg         pause_load;
    reg  [15:0] pause_quanta;
    wire        pause_hold;

    wire rx_queue_flush         = receive_control_one[`MRX_RC_FLUSH_BIT];
    wire udp_sum_check_en       = receive_control_one[`MRX_RC_UDP_BIT];
    wire tcp_sum_check_en       = receive_control_one[`MRX_RC_TCP_BIT];
    wire ip_header_sum_check_en = receive_control_one[`MRX_RC_IP_BIT];
    wire unicast_filter_en      = receive_control_one[`MRX_RC_UCFILT_BIT];
    wire pause_obey_en          = receive_control_one[`MRX_RC_PAUSE_BIT];
    wire crc_error_accept       = receive_control_one[`MRX_RC_CRCACC_BIT];
    wire multicast_filter_en    = receive_control_one[`MRX_RC_MCFILT_BIT];
    wire broadcast_accept       = receive_control_one[`MRX_RC_BCAST_BIT];
    wire all_multicast_accept   = receive_control_one[`MRX_RC_ALLMC_BIT];
    wire own_unicast_accept     = receive_control_one[`MRX_RC_OWNUC_BIT];
    wire promiscuous_accept     = receive_control_one[`MRX_RC_PROMISC_BIT];
    wire inverse_filter_en      = receive_control_one[`MRX_RC_INVERSE_BIT];
    wire rx_run_enable          = receive_control_one[`MRX_RC_RUN_BIT];

    ////////////////////////////////////////////////////////////////////////////////
    // Address classification

    function is_group;
        input [47:0] addr;
        begin
            // First bit on the wire is bit 40 of the address as held here
            is_group = addr[40];
        end
    endfunction

    function is_bcast;
        input [47:0] addr;
        begin
            is_bcast = &addr;
        end
    endfunction

    // Normal address check before inversion
    function addr_check;
        input [47:0] dest;
        input [47:0] own;
        input        hit;
        input        uc_filt;
        input        own_uc;
        input        mc_filt;
        input        bc_acc;
        input        all_mc;
        reg          group;
        reg          bcast;
        reg          match;
        begin
            group      = is_group(dest);
            bcast      = is_bcast(dest);
            match      = (dest == own);
            addr_check = (!group && uc_filt && match) ||
                         (!group && own_uc && match) ||
                         (group && !bcast && mc_filt && hit) ||
                         (bcast && bc_acc) ||
                         (group && all_mc);
        end
    endfunction

    // Inverse mode flips the address check only; promiscuous still takes all
    function addr_decide;
        input normal;
        input promisc;
        input inverse;
        begin
            if (promisc)
                addr_decide = 1'b1;
            else
                addr_decide = inverse ? !normal : normal;
        end
    endfunction

    // One enabled checksum failure is enough to discard the frame
    function sum_check_fail;
        input udp_en;
        input udp;
        input udp_bad;
        input tcp_en;
        input tcp;
        input tcp_bad;
        input ip_en;
        input ip;
        input ip_bad;
        begin
            sum_check_fail = (udp_en && udp && udp_bad) ||
                             (tcp_en && tcp && tcp_bad) ||
                             (ip_en && ip && ip_bad);
        end
    endfunction

    // Store verdict of a closing frame; the drop pulse is its complement
    function frame_keep;
        input started_running;
        input addr_ok;
        input sum_bad;
        input crc_bad;
        begin
            frame_keep = started_running && addr_ok && !sum_bad && !crc_bad;
        end
    endfunction

    wire addr_normal = addr_check(rx_dest_addr, station_addr, hash_hit, unicast_filter_en,
                                  own_unicast_accept, multicast_filter_en,
                                  broadcast_accept, all_multicast_accept);
    wire addr_pass   = addr_decide(addr_normal, promiscuous_accept, inverse_filter_en);
    wire sum_fail    = sum_check_fail(udp_sum_check_en, rx_is_udp, rx_udp_sum_bad,
                                      tcp_sum_check_en, rx_is_tcp, rx_tcp_sum_bad,
                                      ip_header_sum_check_en, rx_is_ip, rx_ip_sum_bad);
    wire crc_fail    = rx_crc_error && !crc_error_accept;

    ////////////////////////////////////////////////////////////////////////////////
    // Register writes and transmit status capture

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            receive_control_one <= `MRX_RC_RESET;
            transmit_status     <= 16'h0000;
        end else begin
            if (reg_write && reg_addr == `MRX_OFS_RX_CTRL_ONE) begin
                receive_control_one <= reg_wdata & `MRX_RC_WRITE_MASK;
            end
            // Whole word replaced at once so flags and id always agree
            if (tx_done) begin
                transmit_status <= 16'h0000;
                transmit_status[`MRX_TXS_LATE_BIT]  <= tx_late_collision;
                transmit_status[`MRX_TXS_MAXCOL_BIT] <= tx_max_collision;
                transmit_status[`MRX_TXS_ID_MSB:0]  <= tx_done_id;
            end
        end
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_read) begin
            case (reg_addr)
                `MRX_OFS_TX_STATUS:   reg_rdata <= transmit_status;
                `MRX_OFS_RX_CTRL_ONE: reg_rdata <= receive_control_one;
                default:              reg_rdata <= 16'h0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Frame acceptance

    localparam [1:0] RX_IDLE     = 2'b00;
    localparam [1:0] RX_IN_FRAME = 2'b01;
    localparam [1:0] RX_FLUSHING = 2'b10;

    reg  [1:0] rx_state;
    reg  [1:0] next_rx_state;
    wire       frame_closing;

    assign in_frame      = (rx_state == RX_IN_FRAME);
    assign frame_closing = in_frame && (next_rx_state == RX_IDLE);

    always @* begin
        next_rx_state = rx_state;
        case (rx_state)
            RX_IDLE, RX_FLUSHING: begin
                // Software is expected to have stopped the receiver first
                if (rx_queue_flush)
                    next_rx_state = RX_FLUSHING;
                else if (rx_frame_start && rx_run_enable)
                    next_rx_state = RX_IN_FRAME;
                else
                    next_rx_state = RX_IDLE;
            end
            RX_IN_FRAME: begin
                // A frame already started finishes even if enable dropped
                if (rx_queue_flush)
                    next_rx_state = RX_FLUSHING;
                else if (rx_frame_start)
                    next_rx_state = RX_IN_FRAME;
                else if (rx_frame_end)
                    next_rx_state = RX_IDLE;
            end
            default: begin
                next_rx_state = RX_IDLE;
            end
        endcase
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_state       <= RX_IDLE;
            frame_ok_run   <= 1'b0;
            rx_frame_store <= 1'b0;
            rx_frame_drop  <= 1'b0;
            rx_running     <= 1'b0;
            rx_queue_clear <= 1'b0;
        end else begin
            rx_state       <= next_rx_state;
            rx_frame_store <= 1'b0;
            rx_frame_drop  <= 1'b0;
            rx_queue_clear <= rx_queue_flush;
            if (rx_queue_flush) begin
                frame_ok_run <= 1'b0;
            end else if (rx_frame_start && (rx_run_enable || in_frame)) begin
                frame_ok_run <= rx_run_enable;
            end
            if (frame_closing) begin
                rx_frame_store <= frame_keep(frame_ok_run, addr_pass, sum_fail, crc_fail);
                rx_frame_drop  <= !frame_keep(frame_ok_run, addr_pass, sum_fail, crc_fail);
            end
            rx_running <= rx_run_enable || in_frame;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pause handling

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pause_load   <= 1'b0;
            pause_quanta <= 16'h0000;
        end else begin
            // Only clean pause frames in full duplex reach the timer
            pause_load   <= rx_frame_end && in_frame && rx_is_pause && !rx_crc_error &&
                            pause_obey_en && full_duplex;
            pause_quanta <= rx_pause_quanta;
        end
    end

    mrx_pause_timer u_pause (
        .clk     (clk),
        .reset_n (reset_n),
        .load    (pause_load),
        .quanta  (pause_quanta),
        .hold    (pause_hold)
    );

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_pause_hold <= 1'b0;
        end else begin
            tx_pause_hold <= pause_hold && full_duplex;
        end
    end

endmodule

// file: mrx_sva.sv
// Checker for the receive control block ports
`timescale 1ns/1ps
module mrx_sva (
    // Clock and reset
    input wire        clk,
    input wire        reset_n,
    // Register port
    input wire [7:0]  reg_addr,
    input wire        reg_write,
    input wire        reg_read,
    input wire [15:0] reg_wdata,
    input wire [15:0] reg_rdata,
    // Frame, link and transmit status
    input wire        full_duplex,
    input wire        rx_frame_end,
    input wire        tx_done,
    input wire [5:0]  tx_done_id,
    input wire        tx_late_collision,
    input wire        tx_max_collision,
    // Results
    input wire        rx_frame_store,
    input wire        rx_frame_drop,
    input wire        rx_queue_clear,
    input wire        tx_pause_hold
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    reg [15:0] ctrl_m;
    reg [15:0] stat_m;
    // Shadows of both registers, updated on the same edges as the block
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_m <= 16'h0800;
            stat_m <= 16'h0000;
        end else begin
            if (reg_write && reg_addr == 8'h74)
                ctrl_m <= reg_wdata & 16'hfff3;
            if (tx_done)
                stat_m <= {2'b00, tx_late_collision, tx_max_collision, 6'h00, tx_done_id};
        end
    end
    a_ctrl_read: assert property (reg_read && reg_addr == 8'h74 |=>
        reg_rdata == $past(ctrl_m)) else $error("control readback wrong");
    a_status_read: assert property (reg_read && reg_addr == 8'h72 |=>
        reg_rdata == $past(stat_m)) else $error("transmit status wrong");
    a_unmapped_zero: assert property (reg_read && reg_addr != 8'h74 && reg_addr != 8'h72
        |=> reg_rdata == 16'h0000) else $error("unmapped read not zero");
    a_rdata_hold: assert property (!reg_read |=> $stable(reg_rdata))
        else $error("read data moved");
    a_verdict_excl: assert property (!(rx_frame_store && rx_frame_drop))
        else $error("store and drop together");
    a_verdict_cause: assert property (rx_frame_store || rx_frame_drop |->
        $past(rx_frame_end)) else $error("verdict without frame end");
    a_flush_follow: assert property (rx_queue_clear == $past(ctrl_m[15]))
        else $error("queue clear not following flush");
    a_pause_duplex: assert property (!full_duplex |=> !tx_pause_hold)
        else $error("pause hold in half duplex");
    a_pause_cause: assert property ($rose(tx_pause_hold) |-> ctrl_m[10] &&
        ($past(rx_frame_end, 2) || $past(rx_frame_end, 3) || $past(rx_frame_end, 4)))
        else $error("pause hold without pause frame");
endmodule
bind mrx_rx_control mrx_sva mrx_sva_inst (.clk(clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .full_duplex(full_duplex),
    .rx_frame_end(rx_frame_end), .tx_done(tx_done), .tx_done_id(tx_done_id),
    .tx_late_collision(tx_late_collision), .tx_max_collision(tx_max_collision),
    .rx_frame_store(rx_frame_store), .rx_frame_drop(rx_frame_drop),
    .rx_queue_clear(rx_queue_clear), .tx_pause_hold(tx_pause_hold));

// file: mrx_net_model.sv
// Network side model handing received frame summaries to the block
`timescale 1ns/1ps
module mrx_net_model (
    // Clock
    input wire        clk,
    // Frame summary
    output reg        f_start,
    output reg        f_end,
    output reg [47:0] f_dest,
    output reg [7:0]  f_fl,
    output reg [15:0] f_q
);
    initial begin
        f_start = 1'b0;
        f_end = 1'b0;
        f_dest = 48'h0;
        f_fl = 8'h00;
        f_q = 16'h0000;
    end
    // Fields are valid only at the end pulse; elsewhere they show junk on purpose
    task send(input [47:0] d, input [7:0] fl, input [15:0] q, input integer len);
        integer i;
        begin
            @(negedge clk);
            f_start = 1'b1;
            f_dest = ~d;
            @(negedge clk);
            f_start = 1'b0;
            for (i = 0; i < len; i = i + 1)
                @(negedge clk);
            f_end = 1'b1;
            f_dest = d;
            f_fl = fl;
            f_q = q;
            @(negedge clk);
            f_end = 1'b0;
            f_dest = ~d;
            f_fl = ~fl;
            f_q = ~q;
        end
    endtask
endmodule

// file: mac_rx_control_tx_status_tb.sv
// Self-checking bench for the receive control block
`timescale 1ns/1ps
module mac_rx_control_tx_status_tb;
    localparam [47:0] sta = 48'h0a1b2c3d4e50;
    localparam [47:0] oth = 48'h0a1b2c3d4e51;
    localparam [47:0] bc  = 48'hffffffffffff;
    localparam [47:0] mc  = 48'h010000000001;
    reg        clk, reset_n, reg_write, reg_read, full_duplex, tx_done, tx_late, tx_max;
    reg        hash_hit;
    reg [7:0]  reg_addr;
    reg [15:0] reg_wdata;
    reg [5:0]  tx_id;
    wire [15:0] reg_rdata, f_q;
    wire [47:0] f_dest;
    wire [7:0]  fl;
    wire        f_start, f_end, store, drop, running, qclr, hold;
    integer    n_fail, comparisons;
    mrx_net_model mrx_net_model_inst (.clk(clk), .f_start(f_start), .f_end(f_end),
        .f_dest(f_dest), .f_fl(fl), .f_q(f_q));
    mrx_rx_control mrx_rx_control_inst (.clk(clk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .station_addr(sta),
        .hash_hit(hash_hit), .full_duplex(full_duplex), .rx_frame_start(f_start),
        .rx_dest_addr(f_dest), .rx_frame_end(f_end), .rx_crc_error(fl[7]),
        .rx_is_ip(fl[6]), .rx_ip_sum_bad(fl[5]), .rx_is_udp(fl[4]),
        .rx_udp_sum_bad(fl[3]), .rx_is_tcp(fl[2]), .rx_tcp_sum_bad(fl[1]),
        .rx_is_pause(fl[0]), .rx_pause_quanta(f_q), .tx_done(tx_done),
        .tx_done_id(tx_id), .tx_late_collision(tx_late), .tx_max_collision(tx_max),
        .rx_frame_store(store), .rx_frame_drop(drop), .rx_running(running),
        .rx_queue_clear(qclr), .tx_pause_hold(hold));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task conclude;
        begin
            if (n_fail == 0 && comparisons > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    task chk(input [15:0] g, input [15:0] e);
        begin
            comparisons = comparisons + 1;
            if (g !== e) begin
                n_fail = n_fail + 1;
                $display("mismatch %0t got %h expected %h", $time, g, e);
            end
        end
    endtask
    task wr(input [7:0] a, input [15:0] d);
        begin
            @(negedge clk);
            reg_addr = a;
            reg_wdata = d;
            reg_write = 1'b1;
            @(negedge clk);
            reg_write = 1'b0;
        end
    endtask
    task rd(input [7:0] a, input [15:0] e);
        begin
            @(negedge clk);
            reg_addr = a;
            reg_read = 1'b1;
            @(negedge clk);
            reg_read = 1'b0;
            chk(reg_rdata, e);
        end
    endtask
    // Verdict code: 2 stored, 1 dropped, 0 no verdict
    task tcase(input [15:0] c, input [47:0] d, input [7:0] f, input [1:0] e);
        begin
            wr(8'h74, c);
            mrx_net_model_inst.send(d, f, 16'h0000, 2);
            chk({14'h0, store, drop}, {14'h0, e});
        end
    endtask
    task tx(input [5:0] id, input l, input m);
        begin
            @(negedge clk);
            tx_id = id;
            tx_late = l;
            tx_max = m;
            tx_done = 1'b1;
            @(negedge clk);
            tx_done = 1'b0;
        end
    endtask
    task wt(input v, input integer lim);
        integer i;
        begin
            i = 0;
            while (hold !== v && i < lim) begin
                @(negedge clk);
                i = i + 1;
            end
            chk({15'h0, hold}, {15'h0, v});
            if (i >= lim)
                conclude;
        end
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_fail = n_fail + 1;
        conclude;
    end
    initial begin
        {reset_n, reg_write, reg_read, tx_done, tx_late, tx_max} = 6'h00;
        full_duplex = 1'b1;
        hash_hit = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        tx_id = 6'h00;
        n_fail = 0;
        comparisons = 0;
        repeat (10) @(posedge clk);
        @(negedge clk);
        reset_n = 1'b1;
        rd(8'h74, 16'h0800);
        rd(8'h72, 16'h0000);
        rd(8'h10, 16'h0000);
        wr(8'h74, 16'hffff);
        rd(8'h74, 16'hfff3);
        tcase(16'h0801, sta, 8'h00, 2);
        chk({15'h0, running}, 16'h0001);
        tcase(16'h0801, oth, 8'h00, 1);
        tcase(16'h0021, sta, 8'h00, 2);
        tcase(16'h0001, sta, 8'h00, 1);
        tcase(16'h0081, bc, 8'h00, 2);
        tcase(16'h0041, bc, 8'h00, 2);
        tcase(16'h0041, mc, 8'h00, 2);
        tcase(16'h0101, mc, 8'h00, 2);
        hash_hit = 1'b0;
        tcase(16'h0101, mc, 8'h00, 1);
        hash_hit = 1'b1;
        tcase(16'h0001, mc, 8'h00, 1);
        tcase(16'h0011, oth, 8'h00, 2);
        tcase(16'h0803, oth, 8'h00, 2);
        tcase(16'h0803, sta, 8'h00, 1);
        tcase(16'h4801, sta, 8'h18, 1);
        tcase(16'h0801, sta, 8'h18, 2);
        tcase(16'h2801, sta, 8'h06, 1);
        tcase(16'h1801, sta, 8'h60, 1);
        tcase(16'h0801, sta, 8'h80, 1);
        tcase(16'h0a01, sta, 8'h80, 2);
        // Enable drops mid-frame: the open frame is still judged
        fork
            mrx_net_model_inst.send(sta, 8'h00, 16'h0000, 6);
            begin
                repeat (3) @(negedge clk);
                wr(8'h74, 16'h0800);
            end
        join
        chk({14'h0, store, drop}, 16'h0002);
        @(negedge clk);
        chk({15'h0, running}, 16'h0000);
        tcase(16'h0800, sta, 8'h00, 0);
        wr(8'h74, 16'h8000);
        @(negedge clk);
        chk({15'h0, qclr}, 16'h0001);
        wr(8'h74, 16'h0000);
        @(negedge clk);
        chk({15'h0, qclr}, 16'h0000);
        tx(6'h2a, 1'b1, 1'b0);
        rd(8'h72, 16'h202a);
        tx(6'h15, 1'b0, 1'b1);
        rd(8'h72, 16'h1015);
        tcase(16'h0c01, sta, 8'h00, 2);
        mrx_net_model_inst.send(sta, 8'h01, 16'h0001, 2);
        wt(1'b1, 10);
        wt(1'b0, 200);
        wr(8'h74, 16'h0801);
        full_duplex = 1'b0;
        mrx_net_model_inst.send(sta, 8'h01, 16'h0001, 2);
        repeat (8) @(negedge clk);
        chk({15'h0, hold}, 16'h0000);
        conclude;
    end
endmodule
